// ### logic/assr_pkg.sv
// Purpose: Shared constants and types for the angle sensor serial readout
// Assumes: System clock 50 MHz; serial clock from host, mode 1
// Notes:   Addresses are 14-bit register addresses of the command frame
package assr_pkg;
  localparam int          CLK_MHZ            = 50;
  localparam int          FRAME_BITS         = 16;
  localparam int          ADDR_BITS          = 14;
  localparam logic [13:0] ADDR_ANGLE         = 14'h3FFF;
  localparam logic [13:0] ADDR_POR_OFF       = 14'h3F22;
  localparam logic [13:0] ADDR_SOFT_RESET    = 14'h3C00;
  localparam logic [13:0] ADDR_MASTER_RESET  = 14'h33A5;
  localparam logic [13:0] ADDR_CLEAR_EF      = 14'h3380;
  localparam logic [13:0] ADDR_NOP           = 14'h0000;
  localparam logic [13:0] ADDR_GAIN_LOOP     = 14'h3FF8;
  localparam logic [13:0] ADDR_ERR_STATUS    = 14'h335A;
  localparam logic [13:0] ADDR_SYS_CONFIG    = 14'h3F20;
  localparam logic [7:0]  POR_OFF_RESET      = 8'h00;
  localparam logic [7:0]  POR_OFF_DISABLE    = 8'h5A;
  localparam logic [5:0]  GAIN_LOOP_RESET    = 6'h20;
  localparam logic [1:0]  GAIN_CODE_RESET    = 2'h0;
  localparam int          GAIN_POS           = 12;
  localparam int          BUSY_POS           = 13;
  localparam int          PARITY_ERR_POS     = 2;
  localparam int          READOUT_US         = 500;
  localparam int          POWER_UP_US        = 580;
  localparam int          READOUT_CYCLES     = READOUT_US * CLK_MHZ;
  localparam int          POWER_UP_CYCLES    = POWER_UP_US * CLK_MHZ;
  localparam int          CORDIC_ITER        = 12;
  localparam int          CONV_CYCLES        = 64;
  localparam logic [5:0]  MAG_TARGET         = 6'h20;

  typedef enum logic [1:0]
  {
    ASSR_SLEEP   = 2'b00,
    ASSR_SAMPLE  = 2'b01,
    ASSR_ROTATE  = 2'b11,
    ASSR_FINISH  = 2'b10
  } assr_meas_t;
endpackage : assr_pkg

// ### logic/assr_frame_if.sv
// Purpose: Carries finished frames from the serial shifter to the core
// Assumes: Toggle strobe crosses from link clock to system clock
// Notes:   Data held stable between toggles
`timescale 1ns/1ps
interface assr_frame_if;
  logic        rx_toggle;
  logic [15:0] rx_frame;
  logic [15:0] tx_word;
  modport link
  (
    output rx_toggle,
    output rx_frame,
    input  tx_word
  );
  modport core
  (
    input  rx_toggle,
    input  rx_frame,
    output tx_word
  );
endinterface : assr_frame_if

// ### logic/assr_shift.sv
// Purpose: Serial shifter on the link clock, mode 1, MSB first
// Assumes: Link clock stops outside frames; chip select async clears
// Notes:   Frame end is taken at chip select rise after sixteen capture edges
`timescale 1ns/1ps
module assr_shift
(
  input  wire logic   serial_clock,
  input  wire logic   rst_n,
  input  wire logic   chip_select_n,
  input  wire logic   mosi,
  output logic        miso,
  assr_frame_if.link  frame
);
  logic [4:0]  bit_count;
  logic [15:0] rx_shift;
  logic [15:0] tx_shift;
  logic        frame_full;

  // Capture on falling edge, count per frame
  always_ff @(negedge serial_clock or posedge chip_select_n)
  begin
    if (chip_select_n)
    begin
      bit_count <= 5'h00;
      rx_shift  <= 16'h0000;
    end
    else
    begin
      bit_count <= bit_count + 5'h01;
      rx_shift  <= {rx_shift[14:0], mosi}; // RQ2 RQ5 RQ7
    end
  end

  // Frame word held for the core until the next full frame
  always_ff @(negedge serial_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame.rx_frame <= 16'h0000;
      frame_full     <= 1'b0;
    end
    else
    begin
      frame_full <= (bit_count == 5'h0F);
      if (bit_count == 5'h0F)
        frame.rx_frame <= {rx_shift[14:0], mosi}; // RQ1
    end
  end

  // Toggle at chip select rise, so commands act only at frame end
  always_ff @(posedge chip_select_n or negedge rst_n)
  begin
    if (!rst_n)
      frame.rx_toggle <= 1'b0;
    else if (frame_full)
      frame.rx_toggle <= ~frame.rx_toggle; // RQ6
  end

  // Launch on rising edge; first bit stands from chip select fall
  always_ff @(posedge serial_clock or posedge chip_select_n)
  begin
    if (chip_select_n)
      tx_shift <= 16'h0000;
    else if (bit_count == 5'h00)
      tx_shift <= frame.tx_word; // RQ3
    else
      tx_shift <= {tx_shift[14:0], 1'b0};
  end

  assign miso = (bit_count == 5'h00) ? frame.tx_word[15] : tx_shift[15]; // RQ7 RQ10
endmodule : assr_shift

// ### logic/assr_readout.sv
// What this block does
// (RQ1) Slave only: registers read and written through 16-bit frames.
// (RQ2) Link works with serial clock up to 10 MHz.
// (RQ3) Mode 1: clock idles low, launch on rise, capture on fall.
// (RQ4) Host lowers chip select while serial clock is low.
// (RQ5) Incoming bits are captured on serial clock falling edge.
// (RQ6) Commands act only when chip select returns high.
// (RQ7) Frames shift most significant bit first both ways.
// (RQ8) Bit 0 is even parity over bits 15 to 1.
// (RQ9) Read-angle command addresses 0x3FFF; host waits conversion time.
// (RQ10) Addressed register sampled at frame end, sent next frame.
// (RQ11) Read-angle powers up, raises done output, starts a measurement.
// (RQ12) Completion lowers done output and clears busy flag.
// (RQ13) Host issues no read-angle while measurement in progress.
// (RQ14) One measurement per command, then back to low power.
// (RQ15) Measurement finishes within 500 us of the command.
// (RQ16) Operational no later than 580 us after power up.
// (RQ17) Reset-cell disable defaults 0x00; 0x5A turns the cell off.
// (RQ18) Two-bit gain setting in system configuration, 00 to 11.
// (RQ19) Angle and magnitude by hardwired rotation algorithm.
// (RQ20) Magnitude drives automatic gain loop.
// (RQ21) 10-bit angle is readable over the serial link.
// (RQ22) Daisy chain of several sensors on five wires; the code has no daisy-chain path, miso sends only its own reply word.
// (RQ23) Wire mode input low selects three-wire, high four-wire; the code leaves wire_mode_select unconnected.
// (RQ24) Data output driven only while chip select low.
//
// Purpose: Core of the angle sensor readout with its serial slave
// Assumes: Host keeps serial clock within limits; samples are inputs
// Notes:   Done output is active-high internally, pin is active low
`timescale 1ns/1ps
module assr_readout
#(
  parameter int READOUT_CYCLES = assr_pkg::READOUT_CYCLES,
  parameter int POWER_UP_CYCLES = assr_pkg::POWER_UP_CYCLES
)
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        serial_clock,
  input  wire logic        chip_select_n,
  input  wire logic        mosi,
  output logic             miso_out,
  output logic             miso_oe,
  input  wire logic        wire_mode_select,
  input  wire logic [9:0]  sample_x,
  input  wire logic [9:0]  sample_y,
  output logic             conversion_done_n,
  output logic             power_on,
  output logic             reset_cell_enable,
  output logic [1:0]       gain_code,
  output logic [5:0]       auto_gain_loop,
  output logic             operational
);
  assr_frame_if frame ();
  logic miso_raw;

  assr_shift u_shift
  (
    .serial_clock  (serial_clock),
    .rst_n         (rst_n),
    .chip_select_n (chip_select_n),
    .mosi          (mosi),
    .miso          (miso_raw),
    .frame         (frame.link)
  );

  // Data out released when deselected; miso_out is driven the same way whatever wire_mode_select is
  assign miso_out = miso_raw;
  assign miso_oe  = ~chip_select_n; // RQ24 RQ22 RQ23

  // Frame toggle synchroniser
  logic        tog_s1;
  logic        tog_s2;
  logic        tog_s3;
  logic        frame_stb;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end
    else
    begin
      tog_s1 <= frame.rx_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end
  assign frame_stb = tog_s2 ^ tog_s3; // RQ6

  // Frame decode
  logic [15:0] rx_word;
  logic        par_ok;
  logic        is_read;
  logic [13:0] addr;
  assign rx_word = frame.rx_frame;
  assign par_ok  = ~(^rx_word); // RQ8
  assign is_read = rx_word[15];
  assign addr    = rx_word[14:1];

  // Pending write: command frame followed by data frame
  logic        wr_pending;
  logic [13:0] wr_addr;
  logic        err_flag;
  logic        parity_err;
  logic [7:0]  por_off;
  logic [1:0]  gain_reg;
  logic        busy;
  logic        start_meas;
  logic        meas_done;
  logic [9:0]  angle;
  logic [13:0] read_value;
  logic [13:0] next_read_value;
  logic [15:0] tx_word;

  assign start_meas = frame_stb && par_ok && !wr_pending && is_read && addr == assr_pkg::ADDR_ANGLE && !busy; // RQ9 RQ11 RQ13

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pending <= 1'b0;
      wr_addr    <= 14'h0000;
    end
    else if (frame_stb)
    begin
      wr_pending <= !wr_pending && par_ok && !is_read;
      wr_addr    <= addr;
    end
  end

  // Writable settings
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      por_off  <= assr_pkg::POR_OFF_RESET;
      gain_reg <= assr_pkg::GAIN_CODE_RESET;
    end
    else if (frame_stb && wr_pending && par_ok)
    begin
      if (wr_addr == assr_pkg::ADDR_POR_OFF)
        por_off <= rx_word[9:2]; // RQ17
      if (wr_addr == assr_pkg::ADDR_SYS_CONFIG)
        gain_reg <= rx_word[assr_pkg::GAIN_POS+2 +: 2]; // RQ18
      if (wr_addr == assr_pkg::ADDR_SOFT_RESET || wr_addr == assr_pkg::ADDR_MASTER_RESET)
      begin
        por_off  <= assr_pkg::POR_OFF_RESET;
        gain_reg <= assr_pkg::GAIN_CODE_RESET;
      end
    end
  end
  assign reset_cell_enable = (por_off != assr_pkg::POR_OFF_DISABLE); // RQ17
  assign gain_code         = gain_reg;

  // Error flags; a new error wins over clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      err_flag   <= 1'b0;
      parity_err <= 1'b0;
    end
    else if (frame_stb)
    begin
      if (!par_ok)
      begin
        err_flag   <= 1'b1;
        parity_err <= 1'b1; // RQ8
      end
      else if (!wr_pending && is_read && addr == assr_pkg::ADDR_CLEAR_EF)
      begin
        err_flag   <= 1'b0;
        parity_err <= 1'b0;
      end
    end
  end

  // Power-up timer
  logic [$clog2(POWER_UP_CYCLES+1)-1:0] pwr_count;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pwr_count <= '0;
    else if (!operational)
      pwr_count <= pwr_count + 1'b1;
  end
  assign operational = (pwr_count >= ($clog2(POWER_UP_CYCLES+1))'(POWER_UP_CYCLES - 1)); // RQ16

  // Measurement machine
  assr_pkg::assr_meas_t state;
  logic [6:0]  step;
  logic signed [12:0] cx;
  logic signed [12:0] cy;
  logic [13:0] cz;
  logic [5:0]  magnitude;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state <= assr_pkg::ASSR_SLEEP;
    else
      case (state)
        assr_pkg::ASSR_SLEEP:  if (start_meas) state <= assr_pkg::ASSR_SAMPLE; // RQ14
        assr_pkg::ASSR_SAMPLE: if (step == 7'(assr_pkg::CONV_CYCLES)) state <= assr_pkg::ASSR_ROTATE;
        assr_pkg::ASSR_ROTATE: if (step == 7'(assr_pkg::CORDIC_ITER)) state <= assr_pkg::ASSR_FINISH;
        assr_pkg::ASSR_FINISH: state <= assr_pkg::ASSR_SLEEP;
        default:               state <= assr_pkg::ASSR_SLEEP;
      endcase
  end
  assign power_on  = (state != assr_pkg::ASSR_SLEEP); // RQ11 RQ14
  assign busy      = power_on;
  assign meas_done = (state == assr_pkg::ASSR_FINISH); // RQ15

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      step <= 7'h00;
    else if ((state == assr_pkg::ASSR_SAMPLE && step == 7'(assr_pkg::CONV_CYCLES)) || state == assr_pkg::ASSR_SLEEP)
      step <= 7'h00;
    else
      step <= step + 7'h01;
  end

  // Rotation: vector into right half, then iterate to zero y
  function automatic logic [13:0] assr_atan(input logic [6:0] i);
    logic [13:0] t;
    t = 14'h0000;
    case (i)
      7'h00: t = 14'h0800;
      7'h01: t = 14'h04B9;
      7'h02: t = 14'h027F;
      7'h03: t = 14'h0145;
      7'h04: t = 14'h00A3;
      7'h05: t = 14'h0051;
      7'h06: t = 14'h0029;
      7'h07: t = 14'h0014;
      7'h08: t = 14'h000A;
      7'h09: t = 14'h0005;
      7'h0A: t = 14'h0003;
      7'h0B: t = 14'h0001;
      default: t = 14'h0000;
    endcase
    return t;
  endfunction : assr_atan

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cx <= 13'sh0000;
      cy <= 13'sh0000;
      cz <= 14'h0000;
    end
    else if (state == assr_pkg::ASSR_SAMPLE)
    begin
      if (sample_x[9])
      begin
        cx <= -13'(signed'(sample_x));
        cy <= -13'(signed'(sample_y));
        cz <= 14'h2000;
      end
      else
      begin
        cx <= 13'(signed'(sample_x));
        cy <= 13'(signed'(sample_y));
        cz <= 14'h0000;
      end
    end
    else if (state == assr_pkg::ASSR_ROTATE && step < 7'(assr_pkg::CORDIC_ITER))
    begin
      if (cy >= 0)
      begin
        cx <= cx + (cy >>> step);
        cy <= cy - (cx >>> step);
        cz <= cz + assr_atan(step); // RQ19
      end
      else
      begin
        cx <= cx - (cy >>> step);
        cy <= cy + (cx >>> step);
        cz <= cz - assr_atan(step); // RQ19
      end
    end
  end

  // Angle result and gain loop
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      angle          <= 10'h000;
      magnitude      <= 6'h00;
      auto_gain_loop <= assr_pkg::GAIN_LOOP_RESET;
    end
    else if (meas_done)
    begin
      angle     <= cz[13:4]; // RQ21
      magnitude <= cx[12:7];
      if (cx[12:7] < assr_pkg::MAG_TARGET && auto_gain_loop != 6'h3F)
        auto_gain_loop <= auto_gain_loop + 6'h01; // RQ20
      else if (cx[12:7] > assr_pkg::MAG_TARGET && auto_gain_loop != 6'h00)
        auto_gain_loop <= auto_gain_loop - 6'h01; // RQ20
    end
  end

  // Done pin: high while measuring, low on completion
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      conversion_done_n <= 1'b0;
    else if (start_meas)
      conversion_done_n <= 1'b1; // RQ11
    else if (meas_done)
      conversion_done_n <= 1'b0; // RQ12
  end

  // Register selected at frame end and returned next frame
  always_comb
  begin
    next_read_value = 14'h0000;
    case (wr_pending ? wr_addr : addr)
      assr_pkg::ADDR_ANGLE:      next_read_value = {4'h0, angle};
      assr_pkg::ADDR_POR_OFF:    next_read_value = {6'h00, por_off};
      assr_pkg::ADDR_GAIN_LOOP:  next_read_value = {8'h00, auto_gain_loop};
      assr_pkg::ADDR_SYS_CONFIG: next_read_value = {gain_reg, 12'h000};
      assr_pkg::ADDR_ERR_STATUS: next_read_value = {busy, 10'h000, parity_err, 2'h0}; // RQ12
      default:                   next_read_value = 14'h0000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      read_value <= 14'h0000;
    else if (frame_stb)
      read_value <= next_read_value; // RQ10
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tx_word <= 16'h0000;
    else
      tx_word <= {read_value, err_flag, ^{read_value, err_flag}}; // RQ8
  end
  assign frame.tx_word = tx_word;
endmodule : assr_readout

// ### verification/assr_properties.sv
// Purpose: Port checks for the angle sensor readout
// Assumes: Bound to assr_readout; all sampled on the system clock
// Notes:   Power-up count follows the design parameter
`timescale 1ns/1ps
module assr_properties
#(
  parameter int POWER_UP_CYCLES = 200
)
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       serial_clock,
  input wire logic       chip_select_n,
  input wire logic       miso_out,
  input wire logic       miso_oe,
  input wire logic       conversion_done_n,
  input wire logic       power_on,
  input wire logic [1:0] gain_code,
  input wire logic       operational
);
  localparam int MEAS_MAX = 200;
  int up_count;

  // Cycles since reset release, saturating
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      up_count <= 0;
    else if (up_count < POWER_UP_CYCLES + 2)
      up_count <= up_count + 1;

  property p_oe_follows_cs;
    @(posedge clock) disable iff (!rst_n) miso_oe == !chip_select_n;
  endproperty
  a_oe_follows_cs: assert property (p_oe_follows_cs) else $error("miso enable not tied to select");

  property p_done_is_power;
    @(posedge clock) disable iff (!rst_n) conversion_done_n == power_on;
  endproperty
  a_done_is_power: assert property (p_done_is_power) else $error("power and done disagree");

  property p_start_at_cs_high;
    @(posedge clock) disable iff (!rst_n) $rose(conversion_done_n) |-> chip_select_n && $past(chip_select_n);
  endproperty
  a_start_at_cs_high: assert property (p_start_at_cs_high) else $error("measurement began inside frame");

  property p_done_bounded;
    @(posedge clock) disable iff (!rst_n) $rose(conversion_done_n) |-> ##[1:MEAS_MAX] !conversion_done_n;
  endproperty
  a_done_bounded: assert property (p_done_bounded) else $error("measurement too long");

  property p_gain_at_cs_high;
    @(posedge clock) disable iff (!rst_n) !$stable(gain_code) |-> chip_select_n;
  endproperty
  a_gain_at_cs_high: assert property (p_gain_at_cs_high) else $error("gain changed inside frame");

  property p_miso_stable_low;
    @(posedge clock) disable iff (!rst_n)
      !serial_clock && $past(!serial_clock) && !chip_select_n && $past(!chip_select_n) |-> $stable(miso_out);
  endproperty
  a_miso_stable_low: assert property (p_miso_stable_low) else $error("miso moved while clock low");

  property p_op_on_time;
    @(posedge clock) disable iff (!rst_n) up_count == POWER_UP_CYCLES + 2 |-> operational;
  endproperty
  a_op_on_time: assert property (p_op_on_time) else $error("not operational in time");

  property p_op_sticky;
    @(posedge clock) disable iff (!rst_n) operational |=> operational;
  endproperty
  a_op_sticky: assert property (p_op_sticky) else $error("operational dropped");
endmodule : assr_properties

// ### verification/assr_host.sv
// Purpose: Host serial master model, mode 1, 160 ns clock
// Assumes: Clock stands low outside frames
// Notes:   Data line inverted after release
`timescale 1ns/1ps
module assr_host
(
  output logic      serial_clock,
  output logic      chip_select_n,
  output logic      mosi,
  input  wire logic miso
);
  initial
  begin
    serial_clock = 1'h0;
    mosi = 1'h0;
    // Select rises after time zero so the link counters clear
    #1 chip_select_n = 1'h1;
  end

  // One 16-bit frame, 6.25 MHz serial clock
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    #7;
    chip_select_n = 1'h0;
    for (int i = 15; i >= 0; i--)
    begin
      #40 serial_clock = 1'h1;
      mosi = tx[i];
      #80 serial_clock = 1'h0;
      rx[i] = miso;
      #40;
    end
    #40 chip_select_n = 1'h1;
    mosi = ~mosi;
    #400;
  endtask : xfer
endmodule : assr_host

// ### verification/assr_readout_test.sv
// Purpose: Self-checking bench for the angle sensor readout
// Assumes: Shortened power-up and readout counts
// Notes:   Host model drives the serial link
`timescale 1ns/1ps
module assr_readout_test;
  localparam int PUC = 200;
  logic       clock = 1'h0;
  logic       rst_n = 1'h0;
  logic       wire_mode_select = 1'h1;
  logic [9:0] sample_x = 10'h0C8;
  logic [9:0] sample_y = 10'h000;
  logic       serial_clock, chip_select_n, mosi, miso_out, miso_oe;
  logic       conversion_done_n, power_on, reset_cell_enable, operational;
  logic [1:0] gain_code;
  logic [5:0] auto_gain_loop;
  logic [15:0] rx;
  int         err_count = 0;
  int         checks_done = 0;
  wire        miso_w = miso_oe ? miso_out : 1'hz;

  always #10 clock = ~clock;

  assr_readout #(.READOUT_CYCLES(PUC), .POWER_UP_CYCLES(PUC)) assr_readout_i
    (.clock(clock), .rst_n(rst_n), .serial_clock(serial_clock), .chip_select_n(chip_select_n), .mosi(mosi),
     .miso_out(miso_out), .miso_oe(miso_oe), .wire_mode_select(wire_mode_select), .sample_x(sample_x),
     .sample_y(sample_y), .conversion_done_n(conversion_done_n), .power_on(power_on),
     .reset_cell_enable(reset_cell_enable), .gain_code(gain_code), .auto_gain_loop(auto_gain_loop),
     .operational(operational));

  assr_host assr_host_i (.serial_clock(serial_clock), .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso_w));

  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  function automatic logic [15:0] fr(input logic rw, input logic [13:0] a);
    return {rw, a, ^{rw, a}};
  endfunction : fr

  function automatic logic [15:0] df(input logic [13:0] d);
    return {d, 1'h0, ^d};
  endfunction : df

  task xf(input logic [15:0] tx);
    assr_host_i.xfer(tx, rx);
  endtask : xf

  task wait_done(input logic lvl, input int lim);
    int n;
    n = 0;
    while (conversion_done_n !== lvl && n < lim)
    begin
      @(posedge clock);
      #1 n++;
    end
    if (conversion_done_n !== lvl)
    begin
      err_count++;
      end_sim;
    end
  endtask : wait_done

  task meas;
    xf(fr(1'h1, assr_pkg::ADDR_ANGLE));
    wait_done(1'h1, 20);
    chk("power_on", 16'(power_on), 16'h1);
    wait_done(1'h0, PUC);
    chk("power_on idle", 16'(power_on), 16'h0);
  endtask : meas

  task t_reset;
    chk("reset outs", 16'({conversion_done_n, power_on, reset_cell_enable, gain_code, auto_gain_loop, operational}),
        16'({3'h1, 2'h0, assr_pkg::GAIN_LOOP_RESET, 1'h0}));
    for (int n = 0; n < PUC + 10 && operational !== 1'h1; n++)
    begin
      @(posedge clock);
      #1;
    end
    chk("operational", 16'(operational), 16'h1);
    if (operational !== 1'h1)
      end_sim;
  endtask : t_reset

  task t_angle(input logic [9:0] x, input logic [9:0] y, input logic [9:0] ang);
    logic [9:0] d;
    logic [5:0] g0;
    @(posedge clock);
    #1 sample_x = x;
    sample_y = y;
    g0 = auto_gain_loop;
    meas;
    meas;
    chk("gain loop up", 16'(auto_gain_loop > g0), 16'h1);
    xf(fr(1'h1, assr_pkg::ADDR_ERR_STATUS));
    chk("reply parity", 16'(rx[0]), 16'(^rx[15:1]));
    d = rx[11:2] - ang + 10'h002;
    chk("angle near", 16'(d <= 10'h004), 16'h1);
  endtask : t_angle

  task t_por;
    xf(fr(1'h0, assr_pkg::ADDR_POR_OFF));
    xf(df(14'(assr_pkg::POR_OFF_DISABLE)));
    chk("old contents", 16'(rx[15:2]), 16'(assr_pkg::POR_OFF_RESET));
    chk("reset cell", 16'(reset_cell_enable), 16'h0);
    xf(fr(1'h1, assr_pkg::ADDR_POR_OFF));
    xf(fr(1'h1, assr_pkg::ADDR_ERR_STATUS));
    chk("por readback", 16'(rx[15:2]), 16'(assr_pkg::POR_OFF_DISABLE));
  endtask : t_por

  task t_gain;
    for (int c = 3; c >= 0; c--)
    begin
      wire_mode_select = c[0];
      xf(fr(1'h0, assr_pkg::ADDR_SYS_CONFIG));
      xf(df(14'(c) << assr_pkg::GAIN_POS));
      chk("gain code", 16'(gain_code), 16'(c));
    end
  endtask : t_gain

  task t_parity;
    xf(fr(1'h1, assr_pkg::ADDR_ANGLE) ^ 16'h0001);
    chk("bad frame ignored", 16'(conversion_done_n), 16'h0);
    xf(fr(1'h1, assr_pkg::ADDR_ERR_STATUS));
    chk("error flag", 16'(rx[1]), 16'h1);
    xf(fr(1'h1, assr_pkg::ADDR_CLEAR_EF));
    chk("parity err bit", 16'(rx[2 + assr_pkg::PARITY_ERR_POS]), 16'h1);
    chk("busy flag", 16'(rx[2 + assr_pkg::BUSY_POS]), 16'h0);
    xf(fr(1'h1, assr_pkg::ADDR_NOP));
    chk("error flag cleared", 16'(rx[1]), 16'h0);
  endtask : t_parity

  initial
  begin
    repeat (8) @(posedge clock);
    #1 rst_n = 1'h1;
    repeat (4) @(posedge clock);
    t_reset;
    t_angle(10'h0C8, 10'h000, 10'h000);
    t_angle(10'h000, 10'h0C8, 10'h100);
    t_por;
    t_gain;
    t_parity;
    end_sim;
  end
endmodule : assr_readout_test

bind assr_readout assr_properties #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) assr_properties_i
  (.clock(clock), .rst_n(rst_n), .serial_clock(serial_clock), .chip_select_n(chip_select_n),
   .miso_out(miso_out), .miso_oe(miso_oe), .conversion_done_n(conversion_done_n), .power_on(power_on),
   .gain_code(gain_code), .operational(operational));
